/* verilog/acqo_pkg.sv */
// Constants for the angle correction and quadrature output block.
// Assumes a 250 MHz mclk and an upstream angle path on the same clock.
`default_nettype none
package acqo_pkg;
  localparam int          ACQO_ANGLE_W       = 15;
  localparam int          ACQO_COEF_W        = 12;
  localparam int          ACQO_NUM_POINTS    = 32;
  localparam int          ACQO_IDX_W         = 5;
  localparam int          ACQO_FRAC_W        = ACQO_ANGLE_W - ACQO_IDX_W;
  localparam int          ACQO_RES_W         = 4;
  // Coefficient LSB equals one angle LSB at scale 0 (2048 LSB = 22.5 deg)
  localparam int          ACQO_COEF_SHIFT0   = 0;
  localparam int          ACQO_COEF_SHIFT1   = 1;
  localparam int          ACQO_COEF_ALIGN    = 0;
  localparam logic [3:0]  ACQO_RES_CODE_MIN  = 4'h3;
  localparam logic [3:0]  ACQO_RES_CODE_MAX  = 4'hE;
  localparam logic [3:0]  ACQO_RES_N_AT_MIN  = 4'hB;
  localparam logic [3:0]  ACQO_RES_DEFAULT_N = 4'hB;
  localparam int          ACQO_MAX_N         = 11;
  localparam int          ACQO_QPOS_W        = ACQO_MAX_N + 2;
  // Pipeline depth of the correction path, equal for both settings
  localparam int          ACQO_LATENCY       = 3;
  typedef enum logic [1:0] {
    ACQO_QSTATE_ONE,
    ACQO_QSTATE_TWO,
    ACQO_QSTATE_THREE,
    ACQO_QSTATE_FOUR
  } acqo_qstate_t;
endpackage : acqo_pkg
`default_nettype wire

/* verilog/acqo_interp.sv */
// Piecewise-linear correction: interpolates between two coefficients.
// Assumes coefficients are stable while sampled; purely combinational.
`default_nettype none
module acqo_interp
  import acqo_pkg::*;
(
  input  wire logic signed [ACQO_COEF_W-1:0]  coef_lo,
  input  wire logic signed [ACQO_COEF_W-1:0]  coef_hi,
  input  wire logic        [ACQO_FRAC_W-1:0]  frac,
  output logic signed      [ACQO_COEF_W+1:0]  corr
);
  logic signed [ACQO_COEF_W+ACQO_FRAC_W+1:0] acc;
  always_comb begin
    // lo*(1-f) + hi*f, midpoint gives the average
    acc = $signed({{(ACQO_FRAC_W+2){coef_lo[ACQO_COEF_W-1]}}, coef_lo} << ACQO_FRAC_W)
        + ($signed({{2{coef_hi[ACQO_COEF_W-1]}}, coef_hi} - {{2{coef_lo[ACQO_COEF_W-1]}}, coef_lo})
           * $signed({1'b0, frac}));
    corr = acc[ACQO_COEF_W+ACQO_FRAC_W+1:ACQO_FRAC_W];
  end
endmodule : acqo_interp
`default_nettype wire

/* verilog/acqo_top.sv */
// Angle correction table and quadrature A/B/index encoder output.
// Assumes angle_valid pulses once per angle update period on mclk.
// Assumes all inputs, coefficient port included, come from logic on mclk.
//
// What this block does
// - Holds 32 coefficients, one per 11.25 degree point from 0 to 348.75.
// - Corrected angle is measured angle minus the correction value.
// - Coefficients are 12-bit two's-complement, -2048 to 2047 LSB.
// - Scale select: 0 gives +-22.5 degrees span, 1 gives +-45 degrees.
// - Between points, correction interpolates linearly; midpoint is the average.
// - Correction on or off keeps the same path latency.
// - With correction disabled, coefficient fields do not affect the angle.
// - A and B make 2^N cycles per turn, 50% duty by angle.
// - B is a quarter cycle ahead of A for increasing angle; each state spans 90e.
// - Index pulse once per revolution at the zero position.
// - States (A,B): one 00, two 01, three 11, four 10.
// - Increasing steps one-two-three-four; decreasing reverse; one edge per step.
// - Increasing: B edge leads A edge; decreasing: A edge leads B.
// - Each quadrature state is 360/(4*2^N) degrees.
// - 4-bit resolution code 3..14 gives N 11..0; others reserved or invalid.
// - Corrected angle updates once per angle period; A/B step one state per clock until caught up.
//
// Implementation choices: strobed register access and the register addresses.
`default_nettype none
module acqo_top
  import acqo_pkg::*;
(
  input  wire logic                           mclk,
  input  wire logic                           rst_n,
  input  wire logic [ACQO_ANGLE_W-1:0]        angle_in,
  input  wire logic                           angle_valid,
  input  wire logic                           correction_enable,
  input  wire logic                           correction_scale_select,
  input  wire logic [ACQO_RES_W-1:0]          encoder_cycle_count_select,
  input  wire logic                           coef_we,
  input  wire logic [ACQO_IDX_W-1:0]          coef_addr,
  input  wire logic [ACQO_COEF_W-1:0]         coef_wdata,
  input  wire logic                           coef_re,
  output logic      [ACQO_COEF_W-1:0]         coef_rdata,
  output logic      [ACQO_ANGLE_W-1:0]        corrected_angle,
  output logic                                quad_a,
  output logic                                quad_b,
  output logic                                quadrature_index_output,
  output logic                                resolution_invalid
);
  // Coefficient table storage
  logic [ACQO_COEF_W-1:0] coef_mem_ff [ACQO_NUM_POINTS];
  logic [ACQO_COEF_W-1:0] nxt_coef_mem [ACQO_NUM_POINTS];
  logic [ACQO_COEF_W-1:0] coef_rdata_ff;
  logic [ACQO_COEF_W-1:0] nxt_coef_rdata;

  genvar gi;
  generate
    for (gi = 0; gi < ACQO_NUM_POINTS; gi++) begin : g_coef
      always_comb begin
        nxt_coef_mem[gi] = coef_mem_ff[gi];
        if (coef_we && (coef_addr == ACQO_IDX_W'(gi))) begin
          nxt_coef_mem[gi] = coef_wdata;
        end
      end
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          coef_mem_ff[gi] <= '0;
        end else begin
          coef_mem_ff[gi] <= nxt_coef_mem[gi];
        end
      end
    end
  endgenerate

  // Read data hold until the next read strobe
  always_comb begin
    nxt_coef_rdata = coef_rdata_ff;
    if (coef_re) begin
      nxt_coef_rdata = coef_mem_ff[coef_addr];
    end
  end

  // Stage 1: look up the two neighbouring points
  logic [ACQO_IDX_W-1:0]            idx_lo;
  logic [ACQO_IDX_W-1:0]            idx_hi;
  logic signed [ACQO_COEF_W+1:0]    corr_w;
  logic [ACQO_ANGLE_W-1:0]          s1_angle_ff;
  logic [ACQO_ANGLE_W-1:0]          nxt_s1_angle;
  logic signed [ACQO_COEF_W+1:0]    s1_corr_ff;
  logic signed [ACQO_COEF_W+1:0]    nxt_s1_corr;
  logic                             s1_vld_ff;
  logic                             nxt_s1_vld;
  logic [ACQO_ANGLE_W-1:0]          s2_angle_ff;
  logic [ACQO_ANGLE_W-1:0]          nxt_s2_angle;
  logic                             s2_vld_ff;
  logic                             nxt_s2_vld;
  logic [ACQO_ANGLE_W-1:0]          corr_aligned;
  logic [ACQO_ANGLE_W-1:0]          out_angle_ff;
  logic [ACQO_ANGLE_W-1:0]          nxt_out_angle;
  logic                             out_vld_ff;
  logic                             nxt_out_vld;

  assign idx_lo = angle_in[ACQO_ANGLE_W-1:ACQO_FRAC_W];
  assign idx_hi = idx_lo + ACQO_IDX_W'(1); // wraps 31 to 0

  acqo_interp u_interp (
    .coef_lo (coef_mem_ff[idx_lo]),
    .coef_hi (coef_mem_ff[idx_hi]),
    .frac    (angle_in[ACQO_FRAC_W-1:0]),
    .corr    (corr_w)
  );

  always_comb begin
    nxt_s1_angle = s1_angle_ff;
    nxt_s1_corr  = s1_corr_ff;
    nxt_s1_vld   = angle_valid;
    if (angle_valid) begin
      nxt_s1_angle = angle_in;
      // Disabled path zeroes the correction, same stages used
      nxt_s1_corr  = correction_enable ? corr_w : '0;
    end
  end

  // Stage 2: scale and subtract, modulo one turn
  always_comb begin
    corr_aligned = ACQO_ANGLE_W'(s1_corr_ff <<< ACQO_COEF_ALIGN);
    // Scale 1 doubles the weight of every coefficient
    if (correction_scale_select) begin
      corr_aligned = ACQO_ANGLE_W'(s1_corr_ff <<< (ACQO_COEF_ALIGN + ACQO_COEF_SHIFT1));
    end
    nxt_s2_vld   = s1_vld_ff;
    nxt_s2_angle = s2_angle_ff;
    if (s1_vld_ff) begin
      nxt_s2_angle = s1_angle_ff - corr_aligned;
    end
  end

  // Stage 3: register the corrected angle for output
  always_comb begin
    nxt_out_vld   = s2_vld_ff;
    nxt_out_angle = out_angle_ff;
    if (s2_vld_ff) begin
      nxt_out_angle = s2_angle_ff;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      coef_rdata_ff <= '0;
      s1_angle_ff   <= '0;
      s1_corr_ff    <= '0;
      s1_vld_ff     <= 1'b0;
      s2_angle_ff   <= '0;
      s2_vld_ff     <= 1'b0;
      out_angle_ff  <= '0;
      out_vld_ff    <= 1'b0;
    end else begin
      coef_rdata_ff <= nxt_coef_rdata;
      s1_angle_ff   <= nxt_s1_angle;
      s1_corr_ff    <= nxt_s1_corr;
      s1_vld_ff     <= nxt_s1_vld;
      s2_angle_ff   <= nxt_s2_angle;
      s2_vld_ff     <= nxt_s2_vld;
      out_angle_ff  <= nxt_out_angle;
      out_vld_ff    <= nxt_out_vld;
    end
  end

  // Resolution decode; reserved and invalid codes freeze the A/B and index outputs
  // Invalid codes fall back to the finest N so the masks stay in range
  logic [3:0] res_n;
  logic       res_bad;
  always_comb begin
    res_bad = (encoder_cycle_count_select < ACQO_RES_CODE_MIN) ||
              (encoder_cycle_count_select > ACQO_RES_CODE_MAX);
    res_n   = ACQO_RES_DEFAULT_N;
    if (!res_bad) begin
      res_n = ACQO_RES_N_AT_MIN - (encoder_cycle_count_select - ACQO_RES_CODE_MIN);
    end
  end

  // Target quadrature position: top N+2 bits of the angle
  logic [ACQO_QPOS_W-1:0] target_q;
  always_comb begin
    target_q = ACQO_QPOS_W'(out_angle_ff >> (ACQO_ANGLE_W - 2 - int'(res_n)));
  end

  // Quadrature stepper
  acqo_qstate_t           qst_ff;
  acqo_qstate_t           nxt_qst;
  logic [ACQO_QPOS_W-1:0] qpos_ff;
  logic [ACQO_QPOS_W-1:0] nxt_qpos;
  logic [ACQO_QPOS_W-1:0] qmask;
  logic [ACQO_QPOS_W-1:0] qdiff;
  logic                   q_a_ff;
  logic                   nxt_q_a;
  logic                   q_b_ff;
  logic                   nxt_q_b;
  logic                   idx_ff;
  logic                   nxt_idx;
  logic                   step_en;
  logic                   step_up;
  logic                   track_ff;
  logic                   nxt_track;

  always_comb begin
    qmask   = ACQO_QPOS_W'((1 << (int'(res_n) + 2)) - 1);
    qdiff   = (target_q - qpos_ff) & qmask;
    // Walk one state per clock until caught up, never skipping a state
    step_en = (out_vld_ff || track_ff) && !res_bad && (qdiff != '0);
    // Shorter way round decides direction
    step_up = !qdiff[int'(res_n) + 1];
    nxt_qpos = qpos_ff;
    nxt_qst  = qst_ff;
    if (step_en) begin
      if (step_up) begin
        nxt_qpos = (qpos_ff + ACQO_QPOS_W'(1)) & qmask;
        case (qst_ff)
          ACQO_QSTATE_ONE:   nxt_qst = ACQO_QSTATE_TWO;
          ACQO_QSTATE_TWO:   nxt_qst = ACQO_QSTATE_THREE;
          ACQO_QSTATE_THREE: nxt_qst = ACQO_QSTATE_FOUR;
          ACQO_QSTATE_FOUR:  nxt_qst = ACQO_QSTATE_ONE;
          default:           nxt_qst = ACQO_QSTATE_ONE;
        endcase
      end else begin
        nxt_qpos = (qpos_ff - ACQO_QPOS_W'(1)) & qmask;
        case (qst_ff)
          ACQO_QSTATE_ONE:   nxt_qst = ACQO_QSTATE_FOUR;
          ACQO_QSTATE_TWO:   nxt_qst = ACQO_QSTATE_ONE;
          ACQO_QSTATE_THREE: nxt_qst = ACQO_QSTATE_TWO;
          ACQO_QSTATE_FOUR:  nxt_qst = ACQO_QSTATE_THREE;
          default:           nxt_qst = ACQO_QSTATE_ONE;
        endcase
      end
    end
    case (nxt_qst)
      ACQO_QSTATE_ONE:   begin nxt_q_a = 1'b0; nxt_q_b = 1'b0; end
      ACQO_QSTATE_TWO:   begin nxt_q_a = 1'b0; nxt_q_b = 1'b1; end
      ACQO_QSTATE_THREE: begin nxt_q_a = 1'b1; nxt_q_b = 1'b1; end
      ACQO_QSTATE_FOUR:  begin nxt_q_a = 1'b1; nxt_q_b = 1'b0; end
      default:           begin nxt_q_a = 1'b0; nxt_q_b = 1'b0; end
    endcase
    // Index stands for the whole state at position zero
    nxt_idx = (nxt_qpos == '0);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      qst_ff  <= ACQO_QSTATE_ONE;
      qpos_ff <= '0;
      q_a_ff  <= 1'b0;
      q_b_ff  <= 1'b0;
      idx_ff  <= 1'b0;
    end else begin
      qst_ff  <= nxt_qst;
      qpos_ff <= nxt_qpos;
      q_a_ff  <= nxt_q_a;
      q_b_ff  <= nxt_q_b;
      idx_ff  <= nxt_idx;
    end
  end

  // Catch-up flag: a fresh sample starts a walk, reaching the target ends it
  always_comb begin
    nxt_track = track_ff;
    if (!step_en) begin
      nxt_track = 1'b0;
    end
    // A new sample in the same cycle wins over the clear
    if (out_vld_ff) begin
      nxt_track = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      track_ff <= 1'b0;
    end else begin
      track_ff <= nxt_track;
    end
  end

  // Invalid-code flag, registered so the output comes from a flop
  logic res_bad_ff;
  logic nxt_res_bad;
  always_comb begin
    nxt_res_bad = res_bad;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      res_bad_ff <= 1'b0;
    end else begin
      res_bad_ff <= nxt_res_bad;
    end
  end

  assign coef_rdata              = coef_rdata_ff;
  assign corrected_angle         = out_angle_ff;
  assign quad_a                  = q_a_ff;
  assign quad_b                  = q_b_ff;
  assign quadrature_index_output = idx_ff;
  assign resolution_invalid      = res_bad_ff;
endmodule : acqo_top
`default_nettype wire

/* tb/acqo_asserts.sv */
// Port checks for acqo_top.
// Assumes one mclk domain, async active-low rst_n.
`default_nettype none
module acqo_asserts
  import acqo_pkg::*;
(
  input wire logic                    mclk,
  input wire logic                    rst_n,
  input wire logic [ACQO_ANGLE_W-1:0] angle_in,
  input wire logic                    angle_valid,
  input wire logic                    correction_enable,
  input wire logic [ACQO_RES_W-1:0]   encoder_cycle_count_select,
  input wire logic                    coef_re,
  input wire logic [ACQO_COEF_W-1:0]  coef_rdata,
  input wire logic [ACQO_ANGLE_W-1:0] corrected_angle,
  input wire logic                    quad_a,
  input wire logic                    quad_b,
  input wire logic                    quadrature_index_output,
  input wire logic                    resolution_invalid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_one_edge_step: assert property (!($changed(quad_a) && $changed(quad_b)))
    else $error("A and B moved together");
  a_fixed_latency: assert property ($changed(corrected_angle) |->
    $past(angle_valid, 3) || $past(angle_valid, 4)) else $error("angle moved off its slot");
  a_bypass_exact: assert property ($past(angle_valid, 4) && !correction_enable &&
    !$past(correction_enable, 4) |-> corrected_angle == $past(angle_in, 4))
    else $error("bypass angle differs");
  a_index_state_one: assert property (quadrature_index_output |-> !quad_a && !quad_b)
    else $error("index outside state one");
  a_index_edge_zero: assert property ($changed(quadrature_index_output) |->
    (!quad_a && !quad_b) || (!$past(quad_a) && !$past(quad_b))) else $error("index edge");
  a_res_flag: assert property ($past(rst_n) |-> resolution_invalid ==
    ($past(encoder_cycle_count_select) < ACQO_RES_CODE_MIN ||
     $past(encoder_cycle_count_select) > ACQO_RES_CODE_MAX)) else $error("invalid flag");
  a_frozen_invalid: assert property (resolution_invalid && $past(resolution_invalid) |->
    $stable(quad_a) && $stable(quad_b)) else $error("stepping while invalid");
  a_rdata_holds: assert property (!$past(coef_re) |-> $stable(coef_rdata))
    else $error("read data moved");
endmodule : acqo_asserts
bind acqo_top acqo_asserts chk_u (.mclk(mclk), .rst_n(rst_n), .angle_in(angle_in),
  .angle_valid(angle_valid), .correction_enable(correction_enable),
  .encoder_cycle_count_select(encoder_cycle_count_select), .coef_re(coef_re),
  .coef_rdata(coef_rdata), .corrected_angle(corrected_angle), .quad_a(quad_a),
  .quad_b(quad_b), .quadrature_index_output(quadrature_index_output),
  .resolution_invalid(resolution_invalid));
`default_nettype wire

/* tb/acqo_rx_model.sv */
// Quadrature receiver: accumulates position from A/B steps.
// Assumes A/B are levels on mclk; mask sets positions per turn.
`default_nettype none
module acqo_rx_model (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        quad_a,
  input  wire logic        quad_b,
  input  wire logic [12:0] mask,
  output logic      [12:0] pos,
  output logic             bad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] g_old;
  wire  [1:0] g_new = {quad_a, quad_a ^ quad_b};
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pos <= 13'h0;
      bad <= 1'b0;
      g_old <= 2'h0;
    end else begin
      g_old <= g_new;
      if (g_new - g_old == 2'h1) pos <= (pos + 13'h1) & mask;
      else if (g_new - g_old == 2'h3) pos <= (pos - 13'h1) & mask;
      else if (g_new != g_old) bad <= 1'b1;
    end
  end
endmodule : acqo_rx_model
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for acqo_top with a receiver model.
// Assumes fixed angle latency and A/B catching up at clock rate.
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((e) !== (g)) begin num_errors++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module testbench
  import acqo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst_n = 1'b0, vld = 1'b0, en = 1'b0, sc = 1'b0, we = 1'b0, re = 1'b0;
  logic [3:0]  res = 4'h3;
  logic [4:0]  addr = 5'h0;
  logic [11:0] wd = 12'h0, rd;
  logic [14:0] ang = 15'h0, ca, a;
  logic [12:0] mask = 13'h1FFF, rx_pos;
  logic qa, qb, qi, rinv, rx_bad;
  logic signed [11:0] coef [32];
  int seed = 32'h4817;
  int num_errors = 0;
  int tests_run = 0;
  bit hung = 1'b0;
  acqo_top dut_u (.mclk(mclk), .rst_n(rst_n), .angle_in(ang), .angle_valid(vld),
    .correction_enable(en), .correction_scale_select(sc), .encoder_cycle_count_select(res),
    .coef_we(we), .coef_addr(addr), .coef_wdata(wd), .coef_re(re), .coef_rdata(rd),
    .corrected_angle(ca), .quad_a(qa), .quad_b(qb), .quadrature_index_output(qi),
    .resolution_invalid(rinv));
  acqo_rx_model rx_u (.mclk(mclk), .rst_n(rst_n), .quad_a(qa), .quad_b(qb), .mask(mask),
    .pos(rx_pos), .bad(rx_bad));
  initial begin
    forever #2 mclk = ~mclk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  task automatic send(input logic [14:0] v);
    ang <= v;
    vld <= 1'b1;
    tick(1);
    vld <= 1'b0;
    tick(6);
  endtask : send
  function automatic logic [14:0] exp_ang(input logic [14:0] v);
    int lo, hi, c;
    lo = int'(coef[v[14:10]]);
    hi = int'(coef[5'(v[14:10] + 5'h1)]);
    c = lo + (((hi - lo) * int'(v[9:0])) >>> 10);
    c = sc ? c * 2 : c;
    return en ? 15'(int'(v) - c) : v;
  endfunction : exp_ang
  task automatic settle(input logic [12:0] e);
    int t;
    for (t = 0; t < 5000 && rx_pos !== e; t++) tick(1);
    if (t == 5000) begin
      $display("mismatch rx_pos_timeout exp %0h got %0h", e, rx_pos);
      num_errors++;
      hung = 1'b1;
    end else begin
      tick(2);
      `CHK("rx_pos", e, rx_pos)
      `CHK("rx_bad", 1'b0, rx_bad)
      `CHK("index", e == 13'h0, qi)
      `CHK("res_invalid", 1'b0, rinv)
    end
  endtask : settle
  initial begin
    for (int i = 0; i < 32; i++) coef[i] = 12'($random(seed));
    coef[0] = 12'h7FF;
    coef[1] = 12'h800;
    tick(10);
    rst_n <= 1'b1;
    tick(1);
    we <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      addr <= 5'(i);
      wd <= coef[i];
      tick(1);
    end
    we <= 1'b0;
    for (int i = 0; i < 32; i++) begin
      addr <= 5'(i);
      re <= 1'b1;
      tick(1);
      re <= 1'b0;
      tick(1);
      `CHK("coef_rdata", coef[i], rd)
    end
    $display("test coef_port done");
    for (int m = 0; m < 3; m++) begin
      en <= (m != 0);
      sc <= (m == 2);
      for (int k = 0; k < 24; k++) begin
        a = k == 0 ? 15'h0 : k == 1 ? 15'h0200 : k == 2 ? 15'h7E00 : 15'($random(seed));
        send(a);
        `CHK("corrected_angle", exp_ang(a), ca)
      end
      $display("test angle mode %0d done", m);
    end
    en <= 1'b0;
    for (int c = 3; c <= 14 && !hung; c++) begin
      res <= 4'(c);
      mask <= 13'((1 << (16 - c)) - 1);
      rst_n <= 1'b0;
      tick(2);
      rst_n <= 1'b1;
      tick(1);
      a = 15'h0;
      for (int k = 0; k < 7 && !hung; k++) begin
        a = k == 6 ? 15'h0 : 15'(a + $random(seed) % 2048);
        send(a);
        settle(13'(a >> (c - 1)));
      end
      $display("test resolution code %0d done", c);
    end
    for (int c = 0; c < 16; c += 15) begin
      res <= 4'(c);
      tick(2);
      `CHK("res_invalid", 1'b1, rinv)
      send(15'h4000);
    end
    $display("test invalid codes done");
    results();
  end
endmodule : testbench
`default_nettype wire
